// ==== core/line_monitor_defs.vh ====
// Purpose: Constants for the line monitor and off mode supervisor
// Assumes: 250 MHz system clock (4 ns period)
// Notes:   Times are kept in their own unit, cycle counts derived from them
`ifndef LINE_MONITOR_DEFS_VH
`define LINE_MONITOR_DEFS_VH

// ----------------------------------------
// Clock
// ----------------------------------------
`define CLK_HZ            250000000

// ----------------------------------------
// Timers (times in microseconds)
// ----------------------------------------
`define DROPOUT_TIME_US   20000
`define DROPOUT_CYCLES    (`DROPOUT_TIME_US * (`CLK_HZ / 1000000))
`define DETECT_TIME_US    32000
`define DETECT_CYCLES     (`DETECT_TIME_US * (`CLK_HZ / 1000000))
`define OFF_FILTER_US     1000
`define OFF_FILTER_CYCLES (`OFF_FILTER_US * (`CLK_HZ / 1000000))
`define SAMPLE_TIME_US    1000
`define SAMPLE_CYCLES     (`SAMPLE_TIME_US * (`CLK_HZ / 1000000))

// ----------------------------------------
// Oscillator
// ----------------------------------------
`define FSW_NOM_HZ        65000
`define FSW_DEV_HZ        4000
`define FM_RATE_HZ        125
`define FM_STEPS          64
`define MAX_DUTY_PCT      80

`endif

// ==== core/line_monitor_off_mode_supervisor.v ====
// Purpose: Brown-out, unplug detection, capacitor discharge, off mode and
//          frequency-modulated oscillator control for a flyback controller
// Assumes: Comparator inputs are asynchronous levels from the analogue front end
// Notes:   Long timers are top-level parameters so simulation can shorten them
`timescale 1ns/1ps
`default_nettype none
`include "line_monitor_defs.vh"

// How it works
// [R1] Line below stop threshold flags brown-out, halts
// [R2] Brown-out keeps supply regulated until start threshold
// [R3] Dropout timer must expire before switching stops
// [R4] Start at next supply turn-on after start threshold
// [R5] Restart after dropout needs first watchdog event
// [R6] Unplug comparator: delayed sample plus offset, no hysteresis
// [R7] Comparator edge resets detect timer; expiry flags DC
// [R8] Only rising slopes count as AC presence; code counts either comparator edge
// [R9] Discharge works in every mode including off
// [R10] Detect timer bounds discharge phases, repeats cyclically
// [R11] Discharge in progress blocks controller start-up
// [R12] Self-supply holds supply during sensing or discharge
// [R13] Feedback below 0.6 V enters off mode
// [R14] Leave off mode only above 2.2 V feedback
// [R15] Off mode keeps only discharge and self-supply
// [R16] Fault latch kept; thermal shutdown uses off mode
// [R17] Off entry filtered by timer on 0.4 V dips
// [R18] Nominal switching frequency fixed per variant
// [R19] Gate duty never exceeds 80 percent
// [R20] Triangular FM plus minus 4 kHz at 125 Hz
// [R21] FM stays active during foldback frequency reduction
// [R22] Controller comes up in off mode after wake
// [R23] Analogue comparators synchronised before use
module line_monitor_off_mode_supervisor #(
  parameter DROPOUT_CYCLES    = `DROPOUT_CYCLES,
  parameter DETECT_CYCLES     = `DETECT_CYCLES,
  parameter OFF_FILTER_CYCLES = `OFF_FILTER_CYCLES,
  parameter SAMPLE_CYCLES     = `SAMPLE_CYCLES
) (
  // Clock and reset (reset = supply wake-up)
  input  wire       i_sys_clk,
  input  wire       i_reset,
  // Line sense comparators
  input  wire       i_line_above_stop,
  input  wire       i_line_above_start,
  input  wire       i_line_above_min,
  input  wire       i_unplug_comparator,
  // Feedback comparators
  input  wire       i_fb_above_off,
  input  wire       i_fb_above_filter,
  input  wire       i_fb_above_on,
  // Supply comparators
  input  wire       i_supply_at_turn_on,
  input  wire       i_supply_below_restart,
  // Protections
  input  wire       i_fault_latch_set,
  input  wire       i_thermal_shutdown,
  input  wire       i_foldback,
  // Outputs
  output reg        o_sample_strobe,
  output reg        o_gate_drive_output,
  output reg        o_brown_out,
  output reg        o_dc_detected,
  output reg        o_discharge_current,
  output reg        o_startup_source,
  output reg        o_off_mode,
  output reg        o_fault_latched,
  output reg        o_running
);

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  localparam NSYNC = 11;
  wire [NSYNC-1:0] async_in = {i_line_above_stop, i_line_above_start, i_line_above_min,
                               i_unplug_comparator, i_fb_above_off, i_fb_above_filter,
                               i_fb_above_on, i_supply_at_turn_on, i_supply_below_restart,
                               i_thermal_shutdown, i_fault_latch_set};
  reg  [NSYNC-1:0] sync_a;   // First stage, read only by sync_b
  reg  [NSYNC-1:0] sync_b;   // Second stage, safe to use

  // Two flops on every analogue comparator output
  always @(posedge i_sys_clk) begin
    sync_a <= async_in;  // R23
    sync_b <= sync_a;    // R23
  end

  wire line_ok_stop  = sync_b[10];
  wire line_ok_start = sync_b[9];
  wire line_ok_min   = sync_b[8];
  wire unplug_cmp    = sync_b[7];
  wire fb_ok_off     = sync_b[6];
  wire fb_ok_filter  = sync_b[5];
  wire fb_ok_on      = sync_b[4];
  wire vcc_on        = sync_b[3];
  wire vcc_restart   = sync_b[2];
  wire thermal_shutdown           = sync_b[1];
  wire fault_in      = sync_b[0];

  reg  unplug_prev;   // Last comparator level for edge detection
  reg  vcc_on_prev;   // Last turn-on level for event detection
  always @(posedge i_sys_clk) begin
    unplug_prev <= unplug_cmp;
    vcc_on_prev <= vcc_on;
  end
  wire unplug_edge = unplug_cmp ^ unplug_prev;
  wire vcc_on_rise = vcc_on & ~vcc_on_prev;

  // ----------------------------------------
  // Unplug detector and discharge
  // ----------------------------------------
  // Analogue compare against delayed sample plus offset happens outside;
  // this block strobes the sample-and-hold every sampling period
  reg [31:0] sample_cnt;   // Sampling period counter
  reg [31:0] detect_cnt;   // Shared detect / discharge-phase timer
  reg        discharging;  // Discharge sequence in progress

  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      sample_cnt      <= 32'h0;
      o_sample_strobe <= 1'b0;
    end else if (sample_cnt >= SAMPLE_CYCLES - 1) begin
      sample_cnt      <= 32'h0;
      o_sample_strobe <= 1'b1;  // R6
    end else begin
      sample_cnt      <= sample_cnt + 32'h1;
      o_sample_strobe <= 1'b0;
    end
  end

  // Runs in all modes; off mode never gates it
  always @(posedge i_sys_clk) begin  // R9
    if (i_reset) begin
      detect_cnt          <= 32'h0;
      discharging         <= 1'b0;
      o_dc_detected       <= 1'b0;
      o_discharge_current <= 1'b0;
    end else if (unplug_edge) begin
      // Any edge, rising or falling, counts as AC present: stop all discharge
      detect_cnt          <= 32'h0;  // R7 R8
      discharging         <= 1'b0;   // R10
      o_dc_detected       <= 1'b0;
      o_discharge_current <= 1'b0;
    end else if (discharging && !line_ok_min) begin
      // Capacitor already safe
      detect_cnt          <= 32'h0;
      discharging         <= 1'b0;   // R10
      o_discharge_current <= 1'b0;
    end else if (detect_cnt >= DETECT_CYCLES - 1) begin
      detect_cnt          <= 32'h0;
      o_dc_detected       <= 1'b1;   // R7
      if (line_ok_min) begin
        // Alternate bounded discharge and sensing phases
        discharging         <= 1'b1;                  // R10
        o_discharge_current <= ~o_discharge_current;  // R10
      end
    end else begin
      detect_cnt <= detect_cnt + 32'h1;
    end
  end

  // ----------------------------------------
  // Brown-out, dropout timer and run state
  // ----------------------------------------
  localparam ST_OFF   = 2'd0;  // Low consumption off mode
  localparam ST_WAIT  = 2'd1;  // Armed, waiting for supply turn-on
  localparam ST_RUN   = 2'd2;  // Switching
  localparam ST_BROWN = 2'd3;  // Brown-out, waiting for line

  reg [1:0]  state;         // Supervisor state
  reg [31:0] dropout_cnt;   // Line dropout timer
  reg [31:0] gtom_cnt;      // Off entry filter timer
  reg        need_wdog;     // Restart blocked until watchdog event
  reg        wdog_seen;     // First watchdog event after dropout

  // Off entry: feedback low for the whole filter time, so short dips never stop us
  wire gtom_done  = (gtom_cnt >= OFF_FILTER_CYCLES - 1);
  wire go_off     = gtom_done || thermal_shutdown;  // R13 R16 R17
  wire start_ok   = line_ok_start && !discharging && (!need_wdog || wdog_seen);

  // Filter timer: counts while either feedback level reads low
  always @(posedge i_sys_clk) begin
    if (i_reset || (fb_ok_off && fb_ok_filter))
      gtom_cnt <= 32'h0;               // R17
    else if (!gtom_done)
      gtom_cnt <= gtom_cnt + 32'h1;    // R17
  end

  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      state           <= ST_OFF;  // R22
      dropout_cnt     <= 32'h0;
      need_wdog       <= 1'b0;
      wdog_seen       <= 1'b0;
      o_brown_out     <= 1'b0;
      o_running       <= 1'b0;
      o_off_mode      <= 1'b1;
      o_fault_latched <= 1'b0;
    end else begin
      // Latch is sticky; off mode does not clear it
      if (fault_in)
        o_fault_latched <= 1'b1;  // R16
      // Watchdog event: unplug comparator edge proves real line
      if (unplug_edge)
        wdog_seen <= 1'b1;        // R5
      case (state)
        ST_OFF: begin
          o_running  <= 1'b0;
          o_off_mode <= 1'b1;     // R15
          if (fb_ok_on && !thermal_shutdown) begin
            state      <= ST_WAIT;  // R14
            o_off_mode <= 1'b0;
          end
        end
        ST_WAIT: begin
          if (go_off) begin
            state <= ST_OFF;
          end else if (vcc_on_rise && start_ok && !o_fault_latched) begin
            state       <= ST_RUN;  // R4 R11 R5
            o_running   <= 1'b1;
            o_brown_out <= 1'b0;
            need_wdog   <= 1'b0;
          end
        end
        ST_RUN: begin
          if (go_off || o_fault_latched) begin
            state     <= ST_OFF;
            o_running <= 1'b0;
          end else if (!line_ok_stop) begin
            // One missing line cycle must not stop us
            if (dropout_cnt >= DROPOUT_CYCLES - 1) begin
              dropout_cnt <= 32'h0;
              state       <= ST_BROWN;  // R1 R3
              o_brown_out <= 1'b1;      // R1
              o_running   <= 1'b0;
              need_wdog   <= 1'b1;      // R5
              wdog_seen   <= unplug_edge;  // An event in the stop cycle still counts
            end else begin
              dropout_cnt <= dropout_cnt + 32'h1;  // R3
            end
          end else begin
            dropout_cnt <= 32'h0;
          end
        end
        ST_BROWN: begin
          if (go_off)
            state <= ST_OFF;
          else if (line_ok_start)
            state <= ST_WAIT;  // R2 R4
        end
        default: state <= ST_OFF;
      endcase
    end
  end

  // ----------------------------------------
  // Self-supply control
  // ----------------------------------------
  // Hysteretic between turn-on and restart levels while running; held at turn-on level when not running; off while line is below minimum
  always @(posedge i_sys_clk) begin
    if (i_reset)
      o_startup_source <= 1'b0;
    else if (!line_ok_min)
      o_startup_source <= 1'b0;
    else if (vcc_on)
      o_startup_source <= 1'b0;     // R2 R12
    else if (vcc_restart || !o_running)
      o_startup_source <= 1'b1;     // R2 R12
  end

  // ----------------------------------------
  // Oscillator with triangular FM
  // ----------------------------------------
  localparam [31:0] P_NOM  = `CLK_HZ / `FSW_NOM_HZ;
  localparam [31:0] P_MIN  = `CLK_HZ / (`FSW_NOM_HZ + `FSW_DEV_HZ);
  localparam [31:0] P_MAX  = `CLK_HZ / (`FSW_NOM_HZ - `FSW_DEV_HZ);
  localparam [31:0] FM_TICK = `CLK_HZ / (`FM_RATE_HZ * 2 * `FM_STEPS);
  localparam [31:0] P_STEP = (P_MAX - P_MIN) / `FM_STEPS;

  reg [31:0] osc_cnt;    // Position in switching period
  reg [31:0] period;     // Current period in cycles
  reg [31:0] fm_cnt;     // FM step prescaler
  reg [6:0]  fm_pos;     // Triangle position
  reg        fm_up;      // Triangle direction

  // Triangle sweeps period around nominal at the FM rate
  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      fm_cnt <= 32'h0;
      fm_pos <= 7'h20;
      fm_up  <= 1'b1;
    end else if (fm_cnt >= FM_TICK - 1) begin
      fm_cnt <= 32'h0;                            // R20 R21
      if (fm_up && fm_pos == 7'h3f)
        fm_up <= 1'b0;
      else if (!fm_up && fm_pos == 7'h01)
        fm_up <= 1'b1;
      fm_pos <= fm_up ? fm_pos + 7'h1 : fm_pos - 7'h1;
    end else begin
      fm_cnt <= fm_cnt + 32'h1;
    end
  end

  // Foldback doubles the whole FM period, so the jitter is doubled with it
  wire [31:0] fm_period = P_MIN + P_STEP * {25'h0, fm_pos};  // R18 R20
  wire [31:0] next_period = i_foldback ? {fm_period[30:0], 1'b0} : fm_period;  // R21
  wire [31:0] on_limit = (period / 32'd100) * `MAX_DUTY_PCT;  // R19

  always @(posedge i_sys_clk) begin
    if (i_reset || !o_running) begin
      osc_cnt             <= 32'h0;
      period              <= P_NOM;
      o_gate_drive_output <= 1'b0;
    end else if (osc_cnt >= period - 1) begin
      osc_cnt             <= 32'h0;
      period              <= next_period;
      o_gate_drive_output <= 1'b1;
    end else begin
      osc_cnt <= osc_cnt + 32'h1;
      if (osc_cnt + 32'h1 >= on_limit)
        o_gate_drive_output <= 1'b0;  // R19
    end
  end

endmodule // line_monitor_off_mode_supervisor
`default_nettype wire

// ==== dv/line_monitor_sva.sv ====
// Purpose: Port assertions for the line monitor supervisor
// Assumes: One clock, synchronous active-high reset
// Notes:   Long waits are counted in helper counters
`timescale 1ns/1ps
`default_nettype none
module line_monitor_sva #(
  parameter DROPOUT_CYCLES    = 200,
  parameter DETECT_CYCLES     = 100,
  parameter OFF_FILTER_CYCLES = 50
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Watched inputs
  input wire logic i_line_above_stop,
  input wire logic i_unplug_comparator,
  input wire logic i_fb_above_off,
  input wire logic i_fb_above_on,
  input wire logic i_foldback,
  // Watched outputs
  input wire logic o_gate_drive_output,
  input wire logic o_brown_out,
  input wire logic o_dc_detected,
  input wire logic o_discharge_current,
  input wire logic o_off_mode,
  input wire logic o_fault_latched,
  input wire logic o_running
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  // Cycles line low, comparator quiet, gate high
  int low_cnt = 0, quiet_cnt = 0, hi_cnt = 0, fbl_cnt = 0;
  always_ff @(posedge i_sys_clk) begin
    low_cnt   <= i_line_above_stop ? 0 : low_cnt + 1;
    fbl_cnt   <= i_fb_above_off ? 0 : fbl_cnt + 1;
    quiet_cnt <= $changed(i_unplug_comparator) ? 0 : quiet_cnt + 1;
    hi_cnt    <= o_gate_drive_output ? hi_cnt + 1 : 0;
  end
  property p_brown_wait; $rose(o_brown_out) |-> low_cnt >= DROPOUT_CYCLES; endproperty
  a_brown_wait: assert property (p_brown_wait) else $error("brown-out too early");
  property p_brown_halt; o_brown_out && $past(o_brown_out) |-> !o_running; endproperty
  a_brown_halt: assert property (p_brown_halt) else $error("running in brown-out");
  property p_dc_quiet; $rose(o_dc_detected) |-> quiet_cnt >= DETECT_CYCLES; endproperty
  a_dc_quiet: assert property (p_dc_quiet) else $error("dc flagged early");
  property p_dc_clear; o_dc_detected && $changed(i_unplug_comparator) |-> ##[1:6] !o_dc_detected;
  endproperty
  a_dc_clear: assert property (p_dc_clear) else $error("dc not cleared");
  property p_no_start; $rose(o_running) |-> !$past(o_discharge_current); endproperty
  a_no_start: assert property (p_no_start) else $error("start while discharging");
  property p_fault_keep; o_fault_latched |=> o_fault_latched; endproperty
  a_fault_keep: assert property (p_fault_keep) else $error("fault latch lost");
  property p_off_exit;
    $fell(o_off_mode) |-> $past(i_fb_above_on, 2) || $past(i_fb_above_on, 5);
  endproperty
  a_off_exit: assert property (p_off_exit) else $error("off exit without high fb");
  // Feedback low past the filter time plus sync and state latency
  property p_off_entry; fbl_cnt >= OFF_FILTER_CYCLES + 4 |-> o_off_mode; endproperty
  a_off_entry: assert property (p_off_entry) else $error("off mode not entered");
  property p_off_quiet; o_off_mode && $past(o_off_mode, 2) |-> !o_gate_drive_output; endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("gate in off mode");
  property p_duty; !i_foldback |-> hi_cnt < 3300; endproperty
  a_duty: assert property (p_duty) else $error("gate duty too long");
  property p_wake; $fell(i_reset) |-> o_off_mode; endproperty
  a_wake: assert property (p_wake) else $error("not off after wake");
  c_brown: cover property ($rose(o_brown_out));
  c_dc: cover property ($rose(o_discharge_current));
  c_run: cover property ($rose(o_running));
endmodule // line_monitor_sva
bind line_monitor_off_mode_supervisor line_monitor_sva #(.DROPOUT_CYCLES(DROPOUT_CYCLES),
  .DETECT_CYCLES(DETECT_CYCLES), .OFF_FILTER_CYCLES(OFF_FILTER_CYCLES))
  line_monitor_sva_inst (.i_sys_clk, .i_reset,
  .i_line_above_stop, .i_unplug_comparator, .i_fb_above_off, .i_fb_above_on, .i_foldback,
  .o_gate_drive_output, .o_brown_out, .o_dc_detected, .o_discharge_current, .o_off_mode,
  .o_fault_latched, .o_running);
`default_nettype wire

// ==== dv/mains_feedback_model.sv ====
// Purpose: Mains, feedback and supply capacitor seen as comparator levels
// Assumes: Levels are coded 0..3 from low to high
// Notes:   Supply is a crude up/down charge count
`timescale 1ns/1ps
`default_nettype none
module mains_feedback_model (
  // Clock
  input  wire logic       i_sys_clk,
  // Scenario controls
  input  wire logic [1:0] i_line_level,
  input  wire logic       i_ac_present,
  input  wire logic [1:0] i_fb_level,
  input  wire logic       i_startup_source,
  // Comparator levels seen by the block
  output wire logic       o_stop,
  output wire logic       o_start,
  output wire logic       o_min,
  output wire logic       o_cmp,
  output wire logic       o_off,
  output wire logic       o_flt,
  output wire logic       o_on,
  output wire logic       o_vcc_on,
  output wire logic       o_vcc_low
);
  logic [5:0] vcc = 6'h00;  // Supply charge
  logic [4:0] ph  = 5'h00;  // Line slope phase
  logic       cmp = 1'b0;
  assign o_min = i_line_level >= 2'h1;
  assign o_stop = i_line_level >= 2'h2;
  assign o_start = i_line_level == 2'h3;
  assign o_flt = i_fb_level >= 2'h1;
  assign o_off = i_fb_level >= 2'h2;
  assign o_on = i_fb_level == 2'h3;
  assign o_cmp = cmp;
  assign o_vcc_on = vcc >= 6'h3c;
  assign o_vcc_low = vcc < 6'h08;
  always @(posedge i_sys_clk) begin
    ph <= ph + 5'h01;
    // DC input leaves the comparator steady low; AC gives pulses
    if (!i_ac_present) begin
      cmp <= 1'b0;
    end else if (ph == 5'h1f) begin
      cmp <= ~cmp;
    end
    if (i_startup_source && vcc != 6'h3f) begin
      vcc <= vcc + 6'h01;
    end else if (!i_startup_source && vcc != 6'h00) begin
      vcc <= vcc - 6'h01;
    end
  end
endmodule // mains_feedback_model
`default_nettype wire

// ==== dv/testbench.sv ====
// Purpose: Self-checking bench for the supervisor
// Assumes: Shortened timers; outputs read on the falling edge
// Notes:   Fault test runs last since the latch is sticky
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int RUN = 0, FLT = 1, OFF = 2, SU = 3, DIS = 4, DC = 5, BRN = 6, GATE = 7;
  logic       i_sys_clk = 1'b0;
  logic       i_reset = 1'b1;
  logic [1:0] line = 2'h3;
  logic [1:0] fb = 2'h0;
  logic       ac = 1'b1, fault = 1'b0, hot = 1'b0, fold = 1'b0;
  wire        l_stop, l_start, l_min, cmp, f_off, f_flt, f_on, s_on, s_low;
  wire  [8:0] outs;
  int         n_mismatch = 0, n_tests = 0, cyc = 0;
  always #2 i_sys_clk = ~i_sys_clk;
  line_monitor_off_mode_supervisor #(.DROPOUT_CYCLES(200), .DETECT_CYCLES(100),
    .OFF_FILTER_CYCLES(50), .SAMPLE_CYCLES(20)) line_monitor_off_mode_supervisor_inst (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_line_above_stop(l_stop),
    .i_line_above_start(l_start), .i_line_above_min(l_min), .i_unplug_comparator(cmp),
    .i_fb_above_off(f_off), .i_fb_above_filter(f_flt), .i_fb_above_on(f_on),
    .i_supply_at_turn_on(s_on), .i_supply_below_restart(s_low), .i_fault_latch_set(fault),
    .i_thermal_shutdown(hot), .i_foldback(fold), .o_sample_strobe(outs[8]),
    .o_gate_drive_output(outs[7]), .o_brown_out(outs[6]), .o_dc_detected(outs[5]),
    .o_discharge_current(outs[4]), .o_startup_source(outs[3]), .o_off_mode(outs[2]),
    .o_fault_latched(outs[1]), .o_running(outs[0]));
  mains_feedback_model mains_feedback_model_inst (.i_sys_clk(i_sys_clk), .i_line_level(line),
    .i_ac_present(ac), .i_fb_level(fb), .i_startup_source(outs[3]), .o_stop(l_stop),
    .o_start(l_start), .o_min(l_min), .o_cmp(cmp), .o_off(f_off), .o_flt(f_flt), .o_on(f_on),
    .o_vcc_on(s_on), .o_vcc_low(s_low));
  task automatic chk(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask
  // Bounded wait for one output to reach a level
  task automatic wt(input int k, input logic v, input int lim, input string nm);
    int i;
    @(negedge i_sys_clk);
    for (i = 0; i < lim && outs[k] !== v; i++) @(negedge i_sys_clk);
    chk(nm, v, outs[k]);
  endtask
  task automatic go(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  task automatic give_verdict();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic t_start();
    go(4);
    chk("off", 1'b1, outs[OFF]);
    chk("run", 1'b0, outs[RUN]);
    wt(8, 1'b1, 30, "strobe");
    @(posedge i_sys_clk);
    fb <= 2'h2;
    go(20);
    chk("off", 1'b1, outs[OFF]);
    @(posedge i_sys_clk);
    fb <= 2'h3;
    wt(OFF, 1'b0, 10, "off");
    wt(RUN, 1'b1, 600, "run");
    wt(GATE, 1'b1, 5000, "gate");
    $display("start done");
  endtask
  task automatic t_dropout();
    @(posedge i_sys_clk);
    line <= 2'h1;
    go(50);
    chk("run", 1'b1, outs[RUN]);
    @(posedge i_sys_clk);
    line <= 2'h3;
    go(10);
    @(posedge i_sys_clk);
    line <= 2'h1;
    wt(BRN, 1'b1, 300, "brown");
    chk("run", 1'b0, outs[RUN]);
    wt(SU, 1'b1, 200, "source");
    @(posedge i_sys_clk);
    line <= 2'h3;
    wt(RUN, 1'b1, 1000, "run");
    $display("dropout done");
  endtask
  task automatic t_unplug();
    // Short dip must be filtered, a long one must reach off mode
    @(posedge i_sys_clk);
    fb <= 2'h1;
    go(20);
    @(posedge i_sys_clk);
    fb <= 2'h3;
    go(60);
    chk("off", 1'b0, outs[OFF]);
    chk("run", 1'b1, outs[RUN]);
    @(posedge i_sys_clk);
    fb <= 2'h1;
    wt(OFF, 1'b1, 70, "off");
    @(posedge i_sys_clk);
    ac <= 1'b0;
    wt(DC, 1'b1, 150, "dc");
    wt(DIS, 1'b1, 10, "discharge");
    wt(DIS, 1'b0, 150, "discharge");
    @(posedge i_sys_clk);
    fb <= 2'h3;
    go(300);
    chk("run", 1'b0, outs[RUN]);
    @(posedge i_sys_clk);
    ac <= 1'b1;
    wt(DC, 1'b0, 60, "dc");
    $display("unplug done");
  endtask
  // Foldback doubles the period; band is twice the FM period limits
  task automatic t_fold();
    int n;
    n = 0;
    @(posedge i_sys_clk);
    fold <= 1'b1;
    wt(RUN, 1'b1, 1000, "run");
    wt(GATE, 1'b1, 5000, "gate");
    while (outs[GATE] === 1'b1 && n < 9000) begin
      @(negedge i_sys_clk);
      n++;
    end
    while (outs[GATE] !== 1'b1 && n < 9000) begin
      @(negedge i_sys_clk);
      n++;
    end
    chk("fold_period", 1'b1, n >= 7246 && n <= 8196);
    wt(GATE, 1'b0, 8000, "gate");
    @(posedge i_sys_clk);
    fold <= 1'b0;
    $display("fold done");
  endtask
  task automatic t_prot();
    @(posedge i_sys_clk);
    hot <= 1'b1;
    wt(OFF, 1'b1, 10, "off");
    @(posedge i_sys_clk);
    hot <= 1'b0;
    fault <= 1'b1;
    wt(FLT, 1'b1, 10, "fault");
    @(posedge i_sys_clk);
    fault <= 1'b0;
    fb <= 2'h1;
    go(20);
    @(posedge i_sys_clk);
    fb <= 2'h3;
    go(300);
    chk("fault", 1'b1, outs[FLT]);
    chk("run", 1'b0, outs[RUN]);
    $display("protect done");
  endtask
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    t_start();
    t_dropout();
    t_unplug();
    t_fold();
    t_prot();
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
